/* common/event_timer_pkg.sv */
// Constants and register layout of the sixteen-bit event timer
package event_timer_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'h04;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'h08;
   localparam logic [7:0] ADDR_IRQ_FLAG = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   // Control register fields
   localparam int CTRL_TIMER_ON = 0;
   localparam int CTRL_CLK_EXT = 1;
   localparam int CTRL_SYNC_DISABLE_N = 2;
   localparam int CTRL_OSC_ENABLE = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   // Flag and enable fields
   localparam int IRQ_OVERFLOW = 0;
   localparam int IRQ_SPECIAL_EVENT = 1;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   // Status fields
   localparam int STAT_ASYNC = 0;
   localparam int STAT_TIMEBASE = 1;
   localparam int STAT_OSC_ACTIVE = 2;
   // Count layout
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   // Compare mode that clears the counter
   localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hB;
   // Internal time base: one tick per four system clocks
   localparam logic [1:0] INT_TICK_LAST = 2'h3;
   // Oscillator activity window: toggles seen within this many cycles
   localparam logic [7:0] OSC_IDLE_LIMIT = 8'hFF;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* hw/ext_clk_edge.sv */
// Rising-edge detector for the external count clock, plain or synchronised
`timescale 1ns/1ps
module ext_clk_edge
   import event_timer_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Clock input and mode
   input wire logic ext_clk,
   input wire logic sync_on,
   // Edge pulse
   output logic rise
);
   logic raw_q, raw_prev_q;
   logic meta_q, sync_q, sync_prev_q;
   logic rise_raw, rise_sync;

   // Single sample path, no metastability guard
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         raw_q <= 1'b0;
         raw_prev_q <= 1'b0;
      end
      else
      begin
         raw_q <= ext_clk;
         raw_prev_q <= raw_q;
      end
   end

   // Two-flop synchroniser, then edge history
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         sync_prev_q <= 1'b0;
      end
      else
      begin
         meta_q <= ext_clk;
         sync_q <= meta_q;
         sync_prev_q <= sync_q;
      end
   end

   assign rise_raw = raw_q & ~raw_prev_q;
   assign rise_sync = sync_q & ~sync_prev_q;
   assign rise = sync_on ? rise_sync : rise_raw;
endmodule

/* hw/timer_osc_ctrl.sv */
// Low-power crystal oscillator drive and activity detect
`timescale 1ns/1ps
module timer_osc_ctrl
   import event_timer_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Enable
   input wire logic osc_enable,
   // Oscillator pins
   input wire logic timer_osc_in_pin,
   output logic timer_osc_out_pin,
   output logic timer_osc_out_oe,
   // Activity
   output logic osc_active
);
   logic in_prev_q;
   logic [7:0] idle_q;
   logic toggled;

   // Inverting amplifier; no halt gating so it runs through halt
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         timer_osc_out_pin <= 1'b0;
         timer_osc_out_oe <= 1'b0;
         in_prev_q <= 1'b0;
      end
      else
      begin
         timer_osc_out_pin <= osc_enable & ~timer_osc_in_pin;
         timer_osc_out_oe <= osc_enable;
         in_prev_q <= timer_osc_in_pin;
      end
   end

   assign toggled = timer_osc_in_pin ^ in_prev_q;

   // Start-up is not timed here; software polls or waits itself
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !osc_enable)
         idle_q <= OSC_IDLE_LIMIT;
      else if (toggled)
         idle_q <= 8'h00;
      else if (idle_q != OSC_IDLE_LIMIT)
         idle_q <= idle_q + 8'h01;
   end

   assign osc_active = (idle_q != OSC_IDLE_LIMIT);
endmodule

/* hw/event_timer.sv */
// Sixteen-bit event timer with AXI4-Lite registers and compare trigger clear
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module event_timer
   import event_timer_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Oscillator pins, input doubles as external count clock
   input wire logic timer_osc_in_pin,
   output logic timer_osc_out_pin,
   output logic timer_osc_out_oe,
   // Low-power halt
   input wire logic low_power_halt,
   output logic wake_req,
   // Capture/compare unit
   input wire logic [3:0] compare_mode_select,
   input wire logic [15:0] compare_value_pair,
   output logic [15:0] count_pair,
   output logic timebase_valid,
   // Converter
   input wire logic adc_enable,
   output logic adc_start,
   // Interrupt
   output logic irq
);
   // Control and interrupt state
   logic [3:0] timer_control_reg_q;
   logic [1:0] periph_irq_flag_reg_q;
   logic [1:0] periph_irq_enable_reg_q;
   logic [15:0] count_q, count_d;
   logic [1:0] tick_div_q;
   logic match_prev_q;
   logic adc_start_q;

   // Bus state
   logic bvalid_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;

   // Decoded control
   logic timer_on, clk_ext, ext_clock_sync_disable_n, timer_osc_enable;
   logic async_mode;
   logic ext_rise, int_tick, count_tick;
   logic wrap, match, special_event;
   logic osc_active;

   // Write decode
   logic wr_fire, wr_lane0;
   logic wr_ctrl, wr_low, wr_high, wr_flag, wr_enable, wr_status, wr_hit;
   logic [7:0] wr_byte;

   // Read decode
   logic rd_fire;
   logic [31:0] rd_word;
   logic rd_hit;

   assign timer_on = timer_control_reg_q[CTRL_TIMER_ON];
   assign clk_ext = timer_control_reg_q[CTRL_CLK_EXT];
   assign ext_clock_sync_disable_n = timer_control_reg_q[CTRL_SYNC_DISABLE_N];
   assign timer_osc_enable = timer_control_reg_q[CTRL_OSC_ENABLE];

   // Asynchronous counting: external clock with synchroniser bypassed
   assign async_mode = clk_ext & ext_clock_sync_disable_n;

   // Edge detect of the external clock
   ext_clk_edge u_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .ext_clk(timer_osc_in_pin),
      .sync_on(~ext_clock_sync_disable_n),
      .rise(ext_rise)
   );

   // Dedicated oscillator
   timer_osc_ctrl u_osc (
      .aclk(aclk),
      .aresetn(aresetn),
      .osc_enable(timer_osc_enable),
      .timer_osc_in_pin(timer_osc_in_pin),
      .timer_osc_out_pin(timer_osc_out_pin),
      .timer_osc_out_oe(timer_osc_out_oe),
      .osc_active(osc_active)
   );

   // Internal time base divider
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tick_div_q <= 2'h0;
      else
         tick_div_q <= (tick_div_q == INT_TICK_LAST) ? 2'h0 : tick_div_q + 2'h1;
   end

   assign int_tick = (tick_div_q == INT_TICK_LAST);

   // Only asynchronous counting keeps ticking in halt
   assign count_tick = timer_on & (clk_ext ? (ext_rise & (async_mode | ~low_power_halt))
                                           : (int_tick & ~low_power_halt));

   // Compare time base is withheld in asynchronous counting
   assign timebase_valid = ~async_mode;
   assign count_pair = count_q;

   // Compare match makes the special event; edge keeps it one pulse
   assign match = (compare_mode_select == MODE_SPECIAL_EVENT) & timebase_valid
                  & (count_q == compare_value_pair);
   assign special_event = match & ~match_prev_q;

   assign wrap = count_tick & (count_q == COUNT_MAX);

   // Bus write channel decode
   assign wr_fire = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
   assign wr_lane0 = s_axi_wstrb[0];
   assign wr_byte = s_axi_wdata[7:0];
   assign wr_ctrl = wr_fire & wr_lane0 & (s_axi_awaddr == ADDR_CTRL);
   assign wr_low = wr_fire & wr_lane0 & (s_axi_awaddr == ADDR_COUNT_LOW);
   assign wr_high = wr_fire & wr_lane0 & (s_axi_awaddr == ADDR_COUNT_HIGH);
   assign wr_flag = wr_fire & wr_lane0 & (s_axi_awaddr == ADDR_IRQ_FLAG);
   assign wr_enable = wr_fire & wr_lane0 & (s_axi_awaddr == ADDR_IRQ_ENABLE);
   assign wr_status = (s_axi_awaddr == ADDR_STATUS);
   assign wr_hit = (s_axi_awaddr == ADDR_CTRL) | (s_axi_awaddr == ADDR_COUNT_LOW)
                 | (s_axi_awaddr == ADDR_COUNT_HIGH) | (s_axi_awaddr == ADDR_IRQ_FLAG)
                 | (s_axi_awaddr == ADDR_IRQ_ENABLE) | wr_status;
   assign s_axi_awready = wr_fire;
   assign s_axi_wready = wr_fire;

   // Next count: write, then trigger clear, then increment.
   // All paths run on aclk, so no ripple carry exists to corrupt on disable.
   always_comb
   begin
      count_d = count_q;
      if (count_tick)
         count_d = count_q + 16'h0001;
      if (special_event)
         count_d = COUNT_RESET;
      if (wr_low)
         count_d[7:0] = wr_byte;
      if (wr_high)
         count_d[15:8] = wr_byte;
   end

   // Count register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         count_q <= COUNT_RESET;
      else
         count_q <= count_d;
   end

   // Trigger edge history and converter start
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         match_prev_q <= 1'b0;
         adc_start_q <= 1'b0;
      end
      else
      begin
         match_prev_q <= match;
         adc_start_q <= special_event & adc_enable;
      end
   end

   assign adc_start = adc_start_q;

   // Control register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         timer_control_reg_q <= CTRL_RESET;
      else if (wr_ctrl)
         timer_control_reg_q <= wr_byte[3:0];
   end

   // Sticky flags: write one clears, a new event wins over the clear.
   // The trigger clear is its own event and never marks an overflow.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         periph_irq_flag_reg_q <= IRQ_RESET;
      else
      begin
         periph_irq_flag_reg_q[IRQ_OVERFLOW] <=
            wrap | (periph_irq_flag_reg_q[IRQ_OVERFLOW]
                    & ~(wr_flag & wr_byte[IRQ_OVERFLOW]));
         periph_irq_flag_reg_q[IRQ_SPECIAL_EVENT] <=
            special_event | (periph_irq_flag_reg_q[IRQ_SPECIAL_EVENT]
                             & ~(wr_flag & wr_byte[IRQ_SPECIAL_EVENT]));
      end
   end

   // Interrupt enable mask
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         periph_irq_enable_reg_q <= IRQ_RESET;
      else if (wr_enable)
         periph_irq_enable_reg_q <= wr_byte[1:0];
   end

   // Level interrupt; also wakes the core from halt
   assign irq = |(periph_irq_flag_reg_q & periph_irq_enable_reg_q);
   assign wake_req = irq;

   // Write response, one cycle after acceptance
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_q <= 1'b1;
         bresp_q <= (wr_hit & ~wr_status) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_q <= 1'b0;
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // Read mux; the count lives on aclk so either byte is always coherent
   assign rd_fire = s_axi_arvalid & ~rvalid_q;
   assign rd_hit = (s_axi_araddr == ADDR_CTRL) | (s_axi_araddr == ADDR_COUNT_LOW)
                 | (s_axi_araddr == ADDR_COUNT_HIGH) | (s_axi_araddr == ADDR_IRQ_FLAG)
                 | (s_axi_araddr == ADDR_IRQ_ENABLE) | (s_axi_araddr == ADDR_STATUS);
   assign rd_word =
      (s_axi_araddr == ADDR_CTRL) ? {28'h0000000, timer_control_reg_q} :
      (s_axi_araddr == ADDR_COUNT_LOW) ? {24'h000000, count_q[7:0]} :
      (s_axi_araddr == ADDR_COUNT_HIGH) ? {24'h000000, count_q[15:8]} :
      (s_axi_araddr == ADDR_IRQ_FLAG) ? {30'h0, periph_irq_flag_reg_q} :
      (s_axi_araddr == ADDR_IRQ_ENABLE) ? {30'h0, periph_irq_enable_reg_q} :
      (s_axi_araddr == ADDR_STATUS) ? {29'h0, osc_active, timebase_valid, async_mode} :
      32'h00000000;
   assign s_axi_arready = rd_fire;

   // Read data, one cycle after acceptance
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= RESP_OKAY;
      end
      else if (rd_fire)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
         rvalid_q <= 1'b0;
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
endmodule

/* test/event_timer_assertions.sv */
// Port-level concurrent checks of the event timer
`timescale 1ns/1ps
module event_timer_assertions
   import event_timer_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Timer side
   input wire logic timer_osc_out_pin,
   input wire logic timer_osc_out_oe,
   input wire logic wake_req,
   input wire logic irq,
   input wire logic [3:0] compare_mode_select,
   input wire logic [15:0] compare_value_pair,
   input wire logic [15:0] count_pair,
   input wire logic timebase_valid,
   input wire logic adc_enable,
   input wire logic adc_start
);
   default clocking
      @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Write taken and compare match
   wire wr = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
   wire hit = compare_mode_select == MODE_SPECIAL_EVENT && count_pair == compare_value_pair;
   // Only the first cycle of a held match clears, else the count would stick
   sequence first_hit;
      hit && !$past(hit);
   endsequence
   sequence sync_trig;
      first_hit ##0 (timebase_valid && !wr);
   endsequence
   write_answer_a: assert property (wr |=> s_axi_bvalid)
      else $error("write not answered");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");
   trigger_clear_a: assert property (sync_trig |=> count_pair == COUNT_RESET)
      else $error("trigger did not clear count");
   trigger_adc_a: assert property (sync_trig ##0 adc_enable |=> adc_start ##1 !adc_start)
      else $error("converter start missing");
   async_keep_a: assert property (hit && !timebase_valid && !wr && count_pair != COUNT_MAX
      && count_pair != COUNT_RESET |=> count_pair != COUNT_RESET) else $error("async clear");
   count_step_a: assert property (!wr && !hit |=> count_pair == $past(count_pair)
      || count_pair == $past(count_pair) + 16'h1) else $error("count jumped");
   write_wins_a: assert property (wr && s_axi_awaddr == ADDR_COUNT_LOW && s_axi_wstrb[0]
      |=> count_pair[7:0] == $past(s_axi_wdata[7:0])) else $error("count write lost");
   wake_irq_a: assert property (wake_req == irq)
      else $error("wake differs from interrupt");
   // Sticky flags: the interrupt may only drop after a register write
   irq_sticky_a: assert property ($fell(irq) |-> $past(wr))
      else $error("interrupt dropped without a write");
   osc_drive_a: assert property (timer_osc_out_pin |-> timer_osc_out_oe)
      else $error("oscillator driven while off");
endmodule

bind event_timer event_timer_assertions chk (
   .aclk(aclk),
   .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .timer_osc_out_pin(timer_osc_out_pin),
   .timer_osc_out_oe(timer_osc_out_oe),
   .wake_req(wake_req),
   .irq(irq),
   .compare_mode_select(compare_mode_select),
   .compare_value_pair(compare_value_pair),
   .count_pair(count_pair),
   .timebase_valid(timebase_valid),
   .adc_enable(adc_enable),
   .adc_start(adc_start)
);

/* test/crystal_model.sv */
// Crystal on the oscillator pins, idle until start-up time has passed
`timescale 1ns/1ps
module crystal_model #(parameter int HALF = 4, parameter int STARTUP = 20)
(
   // Clock
   input wire logic aclk,
   // Amplifier enable
   input wire logic drive_oe,
   // Crystal node
   output logic osc_node = 1'b0
);
   int age = 0;
   int ph = 0;
   // Swings only while the amplifier drives it, also in halt
   always @(posedge aclk)
   begin
      age <= drive_oe ? age + 1 : 0;
      ph <= (ph == HALF - 1) ? 0 : ph + 1;
      if (age < STARTUP)
         osc_node <= 1'b0;
      else if (ph == HALF - 1)
         osc_node <= ~osc_node;
   end
endmodule

/* test/sixteen_bit_event_timer_async_mode_test.sv */
// Self-checking register bench of the event timer
`timescale 1ns/1ps
module sixteen_bit_event_timer_async_mode_test
   import event_timer_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_val;
   logic [3:0] s_axi_wstrb = 4'hF, compare_mode_select = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, low_power_halt = 1'b0, adc_enable = 1'b0;
   logic [15:0] compare_value_pair = 16'h0000, count_pair;
   logic timer_osc_in_pin, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, timer_osc_out_pin, timer_osc_out_oe, wake_req, timebase_valid;
   logic adc_start, irq;
   logic [15:0] pair_val;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int err_count = 0, total_checks = 0, adc_seen = 0;
   event_timer dut (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .timer_osc_in_pin(timer_osc_in_pin),
      .timer_osc_out_pin(timer_osc_out_pin),
      .timer_osc_out_oe(timer_osc_out_oe),
      .low_power_halt(low_power_halt),
      .wake_req(wake_req),
      .compare_mode_select(compare_mode_select),
      .compare_value_pair(compare_value_pair),
      .count_pair(count_pair),
      .timebase_valid(timebase_valid),
      .adc_enable(adc_enable),
      .adc_start(adc_start),
      .irq(irq)
   );
   crystal_model xtal (.aclk(aclk), .drive_oe(timer_osc_out_oe), .osc_node(timer_osc_in_pin));
   // Clock and converter start counter
   always #5 aclk = ~aclk;
   always @(posedge aclk) adc_seen <= adc_seen + int'(adc_start === 1'b1);
   task automatic finish_test;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_range(input logic [31:0] got, input int lo, input int hi);
      total_checks++;
      if ($isunknown(got) || got < lo || got > hi)
      begin
         err_count++;
         $display("ERROR %0t got %h outside %0d..%0d", $time, got, lo, hi);
      end
   endtask
   // Bounded wait for a handshake; a hang ends the run
   task automatic wait_hi(ref logic s);
      int n;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (s !== 1'b1 && n < 200);
      if (s !== 1'b1)
      begin
         err_count++;
         $display("ERROR %0t handshake timed out", $time);
         finish_test();
      end
   endtask
   // Ready raised a cycle late so the response has to wait
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      wait_hi(s_axi_awready);
      s_axi_awvalid <= 1'b0;
      // Data channel is held until its own ready
      if (s_axi_wready !== 1'b1)
         wait_hi(s_axi_wready);
      s_axi_wvalid <= 1'b0;
      @(posedge aclk);
      s_axi_bready <= 1'b1;
      wait_hi(s_axi_bvalid);
      s_axi_bready <= 1'b0;
      check(s_axi_bresp, er);
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      wait_hi(s_axi_arready);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      s_axi_rready <= 1'b1;
      wait_hi(s_axi_rvalid);
      s_axi_rready <= 1'b0;
      rd_val = s_axi_rdata;
      check(s_axi_rresp, er);
      @(posedge aclk);
   endtask
   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // Reset values and refused accesses
      rd(ADDR_CTRL, RESP_OKAY);
      check(rd_val, 32'(CTRL_RESET));
      rd(ADDR_STATUS, RESP_OKAY);
      check(rd_val, 32'h1 << STAT_TIMEBASE);
      rd(8'h18, RESP_SLVERR);
      check(rd_val, 32'h0);
      wr(ADDR_STATUS, 32'h1, RESP_SLVERR);
      $display("test reset done");
      // Wrap sets the sticky flag; interrupt only when enabled
      wr(ADDR_COUNT_LOW, 32'hFE, RESP_OKAY);
      wr(ADDR_COUNT_HIGH, 32'hFF, RESP_OKAY);
      rd(ADDR_COUNT_HIGH, RESP_OKAY);
      check(rd_val, 32'hFF);
      wr(ADDR_CTRL, 32'h1, RESP_OKAY);
      repeat (12) @(posedge aclk);
      wr(ADDR_CTRL, 32'h0, RESP_OKAY);
      check_range({16'h0, count_pair}, 1, 4);
      rd(ADDR_IRQ_FLAG, RESP_OKAY);
      check(rd_val, 32'h1);
      check(irq, 1'b0);
      wr(ADDR_IRQ_ENABLE, 32'h1, RESP_OKAY);
      check({irq, wake_req}, 2'h3);
      wr(ADDR_IRQ_FLAG, 32'h1, RESP_OKAY);
      check(irq, 1'b0);
      $display("test overflow done");
      // Trigger makes the compare value the period
      wr(ADDR_COUNT_LOW, 32'h0, RESP_OKAY);
      compare_mode_select <= MODE_SPECIAL_EVENT;
      compare_value_pair <= 16'h0005;
      adc_enable <= 1'b1;
      wr(ADDR_CTRL, 32'h1, RESP_OKAY);
      repeat (60) @(posedge aclk);
      check_range({16'h0, count_pair}, 0, 5);
      wr(ADDR_CTRL, 32'h0, RESP_OKAY);
      rd(ADDR_IRQ_FLAG, RESP_OKAY);
      check(rd_val, 32'h2);
      check_range(adc_seen, 2, 4);
      wr(ADDR_IRQ_FLAG, 32'h3, RESP_OKAY);
      // Count write coinciding with a new match wins
      wr(ADDR_COUNT_LOW, 32'h3, RESP_OKAY);
      compare_value_pair <= 16'h0003;
      wr(ADDR_COUNT_LOW, 32'h42, RESP_OKAY);
      check({16'h0, count_pair}, 32'h42);
      $display("test trigger done");
      // Raw external count keeps running in halt and is never cleared
      wr(ADDR_COUNT_LOW, 32'h0, RESP_OKAY);
      compare_value_pair <= 16'h0002;
      wr(ADDR_CTRL, 32'hF, RESP_OKAY);
      repeat (30) @(posedge aclk);
      low_power_halt <= 1'b1;
      repeat (80) @(posedge aclk);
      check(timer_osc_out_oe, 1'b1);
      check_range({16'h0, count_pair}, 3, 16);
      check(timebase_valid, 1'b0);
      low_power_halt <= 1'b0;
      rd(ADDR_STATUS, RESP_OKAY);
      check(rd_val, 32'h5);
      $display("test async done");
      // Synchronised external count follows the crystal edges
      compare_mode_select <= 4'h0;
      wr(ADDR_CTRL, 32'h8, RESP_OKAY);
      wr(ADDR_COUNT_LOW, 32'h0, RESP_OKAY);
      wr(ADDR_CTRL, 32'hB, RESP_OKAY);
      repeat (80) @(posedge aclk);
      check_range({16'h0, count_pair}, 8, 12);
      // Byte-wise read near a low-byte wrap; high byte re-read on wrap
      wr(ADDR_CTRL, 32'h8, RESP_OKAY);
      wr(ADDR_COUNT_LOW, 32'hFE, RESP_OKAY);
      wr(ADDR_COUNT_HIGH, 32'h0, RESP_OKAY);
      wr(ADDR_CTRL, 32'hB, RESP_OKAY);
      rd(ADDR_COUNT_LOW, RESP_OKAY);
      pair_val[7:0] = rd_val[7:0];
      rd(ADDR_COUNT_HIGH, RESP_OKAY);
      pair_val[15:8] = rd_val[7:0];
      rd(ADDR_COUNT_LOW, RESP_OKAY);
      if (rd_val[7:0] < pair_val[7:0])
      begin
         pair_val[7:0] = rd_val[7:0];
         rd(ADDR_COUNT_HIGH, RESP_OKAY);
         pair_val[15:8] = rd_val[7:0];
      end
      check_range({16'h0, pair_val}, 16'h00FE, 16'h0103);
      $display("test sync done");
      finish_test();
   end
endmodule
